/* File: verilog/scd_pkg.sv */
package scd_pkg;

    // four-level strap codes
    typedef logic [1:0] scd_level_t;
    localparam scd_level_t LVL_ZERO = 2'h0;
    localparam scd_level_t LVL_THIRD = 2'h1;
    localparam scd_level_t LVL_TWO_THIRDS = 2'h2;
    localparam scd_level_t LVL_ONE = 2'h3;

    localparam int RATIO_W = 6;
    localparam int PHASE_W = 4;
    localparam int INDEX_W = 4;
    localparam int DELAY_W = 14;
    localparam int PROD_W = 18;
    localparam int FRAC_SHIFT = 4;
    localparam int RESUME_W = 3;

    localparam logic [RATIO_W-1:0] RATIO_BYPASS = 6'h01;
    localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ALIGN_MIN_NS = 5;
    localparam int ALIGN_MIN_CYCLES =
        (ALIGN_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [RESUME_W-1:0] RESUME_CYCLES = 3'h4;
    localparam logic [RESUME_W-1:0] RESUME_LAST = 3'h1;

    // delay full scale in ps
    localparam logic [DELAY_W-1:0] FS_SHORT_PS = 14'h0708;
    localparam logic [DELAY_W-1:0] FS_MID_PS = 14'h1770;
    localparam logic [DELAY_W-1:0] FS_LONG_PS = 14'h2d50;

    typedef enum logic [1:0] {DIV_HELD, DIV_WAIT, DIV_RUN} scd_div_e;

    typedef struct packed {
        logic on;
        logic [RATIO_W-1:0] ratio;
        logic [PHASE_W-1:0] phase;
    } scd_div_cfg_s;

    typedef struct packed {
        scd_div_e st;
        logic [RATIO_W-1:0] cnt;
        logic [PHASE_W-1:0] ph;
        logic lvl;
    } scd_div_state_s;

    typedef struct packed {
        logic loaded;
        logic hold;
        logic [RESUME_W-1:0] resume;
        scd_div_cfg_s cfg0;
        scd_div_cfg_s cfg1;
        scd_div_cfg_s cfg2;
        logic delay_en;
        logic [DELAY_W-1:0] delay_ps;
        logic [2:0] bypass;
    } scd_top_s;

    function automatic logic [RATIO_W-1:0] scd_ratio_std(
        input logic [INDEX_W-1:0] idx);
        case (idx)
            4'h0: scd_ratio_std = 6'h01;
            4'h1: scd_ratio_std = 6'h02;
            4'h2: scd_ratio_std = 6'h03;
            4'h3: scd_ratio_std = 6'h04;
            4'h4: scd_ratio_std = 6'h05;
            4'h5: scd_ratio_std = 6'h06;
            4'h6: scd_ratio_std = 6'h08;
            4'h7: scd_ratio_std = 6'h09;
            4'h8: scd_ratio_std = 6'h0a;
            4'h9: scd_ratio_std = 6'h0c;
            4'ha: scd_ratio_std = 6'h0f;
            4'hb: scd_ratio_std = 6'h10;
            4'hc: scd_ratio_std = 6'h12;
            4'hd: scd_ratio_std = 6'h18;
            4'he: scd_ratio_std = 6'h1e;
            default: scd_ratio_std = 6'h20;
        endcase
    endfunction

    function automatic logic [RATIO_W-1:0] scd_ratio_alt(
        input logic [INDEX_W-1:0] idx);
        case (idx)
            4'h0: scd_ratio_alt = 6'h07;
            4'h1: scd_ratio_alt = 6'h0b;
            4'h2: scd_ratio_alt = 6'h0d;
            4'h3: scd_ratio_alt = 6'h0e;
            4'h4: scd_ratio_alt = 6'h11;
            4'h5: scd_ratio_alt = 6'h13;
            4'h6: scd_ratio_alt = 6'h14;
            4'h7: scd_ratio_alt = 6'h15;
            4'h8: scd_ratio_alt = 6'h16;
            4'h9: scd_ratio_alt = 6'h17;
            4'ha: scd_ratio_alt = 6'h19;
            4'hb: scd_ratio_alt = 6'h1a;
            4'hc: scd_ratio_alt = 6'h1b;
            4'hd: scd_ratio_alt = 6'h1c;
            4'he: scd_ratio_alt = 6'h1d;
            default: scd_ratio_alt = 6'h1f;
        endcase
    endfunction

    function automatic logic [DELAY_W-1:0] scd_full_scale(
        input scd_level_t lvl);
        case (lvl)
            LVL_THIRD: scd_full_scale = FS_SHORT_PS;
            LVL_TWO_THIRDS: scd_full_scale = FS_MID_PS;
            LVL_ONE: scd_full_scale = FS_LONG_PS;
            default: scd_full_scale = 14'h0000;
        endcase
    endfunction

endpackage

/* File: verilog/scd_divider.sv */
`timescale 1ns/1ps
module scd_divider
    import scd_pkg::*;
(
    input wire logic i_core_clk, // input clock
    input wire logic i_sys_rst, // async reset, high
    input wire scd_div_cfg_s i_cfg, // ratio, phase, enable
    input wire logic i_hold, // freeze in fixed state
    input wire logic i_start, // alignment release pulse
    output logic o_clk_level // divided output level
);
    scd_div_state_s st_reg;
    scd_div_state_s st_next;
    logic [RATIO_W-1:0] half;
    logic [RATIO_W-1:0] cnt_inc;

    assign half = i_cfg.ratio >> 1;
    assign cnt_inc = (st_reg.cnt == i_cfg.ratio - RATIO_BYPASS) ?
                     '0 : st_reg.cnt + RATIO_BYPASS;

    always_comb begin
        st_next = st_reg;
        case (st_reg.st)
            DIV_HELD: begin
                if (i_start) begin
                    if (i_cfg.phase == PHASE_ZERO) begin // see R10
                        st_next.st = DIV_RUN;
                        st_next.cnt = '0;
                        st_next.lvl = 1'b1;
                    end else begin
                        st_next.st = DIV_WAIT;
                        st_next.ph = i_cfg.phase - 4'h1; // see R11, R12
                    end
                end
            end
            DIV_WAIT: begin
                if (st_reg.ph == PHASE_ZERO) begin // see R10
                    st_next.st = DIV_RUN;
                    st_next.cnt = '0;
                    st_next.lvl = 1'b1;
                end else begin
                    st_next.ph = st_reg.ph - 4'h1;
                end
            end
            DIV_RUN: begin
                st_next.cnt = cnt_inc;
                st_next.lvl = (cnt_inc < half); // see R09
            end
            default: st_next.st = DIV_HELD;
        endcase
        // frozen low while aligning, off or bypassed
        if (i_hold || !i_cfg.on || i_cfg.ratio == RATIO_BYPASS) begin
            st_next.st = DIV_HELD; // see R13
            st_next.cnt = '0;
            st_next.ph = '0;
            st_next.lvl = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '{st: DIV_HELD, cnt: '0, ph: '0, lvl: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_clk_level = st_reg.lvl;

    sequence high_two_low_two;
        o_clk_level ##1 !o_clk_level ##1 !o_clk_level ##1 o_clk_level;
    endsequence

    div4_period_a: assert property (@(posedge i_core_clk) // see R09
        disable iff (i_sys_rst || i_hold)
        $rose(o_clk_level) && i_cfg.ratio == 6'h04 |=> high_two_low_two)
        else $error("divide by 4 not two high two low");

    div3_duty_a: assert property (@(posedge i_core_clk) // see R09
        disable iff (i_sys_rst || i_hold)
        $rose(o_clk_level) && i_cfg.ratio == 6'h03
        |=> !o_clk_level ##1 !o_clk_level ##1 o_clk_level)
        else $error("divide by 3 not one high two low");

    phase_wait_a: assert property (@(posedge i_core_clk) // see R10
        disable iff (i_sys_rst || i_hold)
        st_reg.st == DIV_HELD && i_start && i_cfg.phase == 4'h2 &&
        i_cfg.on && i_cfg.ratio != RATIO_BYPASS
        |=> !o_clk_level[*2] ##1 o_clk_level)
        else $error("phase offset 2 did not wait two cycles");

    hold_low_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        i_hold |=> !o_clk_level)
        else $error("output not frozen low during alignment");

endmodule

/* File: verilog/scd_clock_distributor.sv */
`timescale 1ns/1ps
// How it works
// R01 - range not zero: third delay N/16 full; the code also needs usage not zero, else the delay is off and zero
// R02 - range zero: fine index is third phase
// R03 - usage third/one: ratio-B sets third ratio
// R04 - usage zero: ratio-B is second phase
// R05 - usage not one: ratio-C sets second ratio
// R06 - usage one, range set: ratio-C third phase
// R07 - usage not two-thirds: ratio-A first ratio
// R08 - usage two-thirds: ratio-A alternate list, third
// R09 - high time is floor of ratio/2
// R10 - wait phase-offset cycles before first edge
// R11 - offset equal to ratio matches zero
// R12 - offsets up to 15 accepted
// R13 - align low freezes, resume four cycles later
// R14 - divide by one bypasses, ignores align
// R15 - strap pair: first low, second high digit
// R16 - range strap: bypass, 1.8, 6.0, 11.6 ns
// R17 - straps latched once after reset
module scd_clock_distributor
    import scd_pkg::*;
(
    input wire logic i_core_clk, // fast input clock
    input wire logic i_sys_rst, // async reset, high
    input wire logic i_align_request_n, // align, active low
    input wire scd_level_t i_delay_range_strap, // delay full scale
    input wire scd_level_t i_output_usage_strap, // outputs in use
    input wire scd_level_t i_fine_low_strap, // fine word low digit
    input wire scd_level_t i_fine_high_strap, // fine word high digit
    input wire scd_level_t i_ratio_b_low_strap, // pair b low digit
    input wire scd_level_t i_ratio_b_high_strap, // pair b high digit
    input wire scd_level_t i_ratio_c_low_strap, // pair c low digit
    input wire scd_level_t i_ratio_c_high_strap, // pair c high digit
    input wire scd_level_t i_ratio_a_low_strap, // pair a low digit
    input wire scd_level_t i_ratio_a_high_strap, // pair a high digit
    output logic o_first_clock_output, // divided first output
    output logic o_second_clock_output, // divided second output
    output logic o_third_clock_output, // divided third output
    output logic [2:0] o_clock_bypass, // output follows input clk
    output logic [2:0] o_output_on, // output in use
    output logic o_delay_enable, // third output delay active
    output logic [DELAY_W-1:0] o_third_delay_ps, // delay in ps
    output logic o_config_loaded, // straps captured
    output logic o_aligning // dividers held or resuming
);
    scd_top_s st_reg;
    scd_top_s st_next;
    logic [INDEX_W-1:0] idx_fine;
    logic [INDEX_W-1:0] idx_a;
    logic [INDEX_W-1:0] idx_b;
    logic [INDEX_W-1:0] idx_c;
    logic [PROD_W-1:0] delay_prod;
    logic align_start;
    logic div_hold;

    // first strap of a pair is the low digit
    assign idx_fine = {i_fine_high_strap, i_fine_low_strap}; // see R15
    assign idx_a = {i_ratio_a_high_strap, i_ratio_a_low_strap}; // see R15
    assign idx_b = {i_ratio_b_high_strap, i_ratio_b_low_strap}; // see R15
    assign idx_c = {i_ratio_c_high_strap, i_ratio_c_low_strap}; // see R15

    // fraction N/16 of the selected full scale
    assign delay_prod = PROD_W'(scd_full_scale(i_delay_range_strap)) *
                        PROD_W'(idx_fine); // see R16

    // release pulse on the fourth cycle after the pin goes high
    assign align_start = st_reg.hold && i_align_request_n &&
                         st_reg.resume == RESUME_LAST; // see R13
    assign div_hold = st_reg.hold && !align_start;

    always_comb begin
        st_next = st_reg;
        if (!st_reg.loaded) begin
            // straps are sampled once; later changes need a reset
            st_next.loaded = 1'b1; // see R17
            st_next.hold = 1'b1;
            st_next.resume = RESUME_CYCLES;

            st_next.cfg0.on = (i_output_usage_strap != LVL_TWO_THIRDS);
            st_next.cfg0.ratio = scd_ratio_std(idx_a); // see R07
            st_next.cfg0.phase = PHASE_ZERO;

            st_next.cfg1.on = (i_output_usage_strap != LVL_ONE);
            st_next.cfg1.ratio = scd_ratio_std(idx_c); // see R05
            if (i_output_usage_strap == LVL_ZERO) begin
                st_next.cfg1.phase = idx_b; // see R04
            end else begin
                st_next.cfg1.phase = PHASE_ZERO;
            end

            st_next.cfg2.on = (i_output_usage_strap != LVL_ZERO);
            if (i_output_usage_strap == LVL_TWO_THIRDS) begin
                st_next.cfg2.ratio = scd_ratio_alt(idx_a); // see R08
            end else begin
                st_next.cfg2.ratio = scd_ratio_std(idx_b); // see R03
            end
            if (i_delay_range_strap == LVL_ZERO) begin
                st_next.cfg2.phase = idx_fine; // see R02
            end else if (i_output_usage_strap == LVL_ONE) begin
                st_next.cfg2.phase = idx_c; // see R06
            end else begin
                st_next.cfg2.phase = PHASE_ZERO;
            end

            st_next.delay_en = (i_delay_range_strap != LVL_ZERO) &&
                               (i_output_usage_strap != LVL_ZERO);
            if (st_next.delay_en) begin
                st_next.delay_ps =
                    delay_prod[PROD_W-1:FRAC_SHIFT]; // see R01
            end else begin
                st_next.delay_ps = '0;
            end

            st_next.bypass[0] = st_next.cfg0.on &&
                                st_next.cfg0.ratio == RATIO_BYPASS;
            st_next.bypass[1] = st_next.cfg1.on &&
                                st_next.cfg1.ratio == RATIO_BYPASS;
            st_next.bypass[2] = st_next.cfg2.on &&
                                st_next.cfg2.ratio == RATIO_BYPASS;
        end else if (!i_align_request_n) begin
            // any sampled low freezes the dividers
            st_next.hold = 1'b1; // see R13
            st_next.resume = RESUME_CYCLES;
        end else if (st_reg.hold) begin
            if (align_start) begin
                st_next.hold = 1'b0; // see R13
                st_next.resume = '0;
            end else begin
                st_next.resume = st_reg.resume - RESUME_LAST;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // bypassed outputs hold their divider low and ignore alignment
    scd_divider u_div_first (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_cfg(st_reg.cfg0),
        .i_hold(div_hold),
        .i_start(align_start),
        .o_clk_level(o_first_clock_output)
    ); // see R14

    scd_divider u_div_second (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_cfg(st_reg.cfg1),
        .i_hold(div_hold),
        .i_start(align_start),
        .o_clk_level(o_second_clock_output)
    );

    scd_divider u_div_third (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_cfg(st_reg.cfg2),
        .i_hold(div_hold),
        .i_start(align_start),
        .o_clk_level(o_third_clock_output)
    );

    assign o_clock_bypass = st_reg.bypass; // see R14
    assign o_output_on = {st_reg.cfg2.on, st_reg.cfg1.on, st_reg.cfg0.on};
    assign o_delay_enable = st_reg.delay_en;
    assign o_third_delay_ps = st_reg.delay_ps;
    assign o_config_loaded = st_reg.loaded;
    assign o_aligning = st_reg.hold;

    sequence pin_released;
        st_reg.loaded && st_reg.hold && $rose(i_align_request_n);
    endsequence

    sequence stays_high_three;
        i_align_request_n[*3];
    endsequence

    resume_four_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        pin_released ##1 stays_high_three |-> align_start)
        else $error("align release not four cycles after pin high");

    resume_not_early_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        pin_released |-> !align_start[*3])
        else $error("dividers resumed before four cycles");

    align_freeze_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        st_reg.loaded && !i_align_request_n
        |=> o_aligning ##1 !o_second_clock_output || o_clock_bypass[1])
        else $error("align low did not freeze the dividers");

    bypass_quiet_a: assert property (@(posedge i_core_clk) // see R14
        disable iff (i_sys_rst)
        o_clock_bypass[0] |-> !o_first_clock_output)
        else $error("bypassed divider is toggling");

    cfg_stable_a: assert property (@(posedge i_core_clk) // see R17
        disable iff (i_sys_rst)
        st_reg.loaded |=> $stable(st_reg.cfg2) && $stable(st_reg.cfg0))
        else $error("configuration changed after capture");

    long_delay_a: assert property (@(posedge i_core_clk) // see R01
        disable iff (i_sys_rst)
        !st_reg.loaded && i_delay_range_strap == LVL_ONE &&
        i_output_usage_strap != LVL_ZERO && idx_fine == 4'hf
        |=> o_delay_enable && o_third_delay_ps == 14'h2a7b)
        else $error("fifteen sixteenths of 11.6 ns not 10875 ps");

    fine_phase_a: assert property (@(posedge i_core_clk) // see R02
        disable iff (i_sys_rst)
        !st_reg.loaded && i_delay_range_strap == LVL_ZERO
        |=> !o_delay_enable && st_reg.cfg2.phase == $past(idx_fine))
        else $error("fine index not used as third phase");

    alt_ratio_a: assert property (@(posedge i_core_clk) // see R08
        disable iff (i_sys_rst)
        !st_reg.loaded && i_output_usage_strap == LVL_TWO_THIRDS &&
        idx_a == 4'h0
        |=> st_reg.cfg2.ratio == 6'h07 && !o_output_on[0])
        else $error("usage two-thirds did not pick divide by 7");

    load_first_a: assert property (@(posedge i_core_clk) // see R17
        disable iff (i_sys_rst)
        !st_reg.loaded |=> st_reg.loaded && o_aligning)
        else $error("straps not captured on first edge");

    load_once_a: assert property (@(posedge i_core_clk) // see R17
        disable iff (i_sys_rst)
        st_reg.loaded |=> st_reg.loaded)
        else $error("strap capture lost without reset");

    pin_low_hold_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        st_reg.loaded && !i_align_request_n
        |=> o_aligning && st_reg.resume == RESUME_CYCLES)
        else $error("align low did not restart the countdown");

    start_clears_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        align_start |=> !o_aligning)
        else $error("aligning still set after release");

    first_edge_a: assert property (@(posedge i_core_clk) // see R10
        disable iff (i_sys_rst)
        align_start && st_reg.cfg0.on && !st_reg.bypass[0]
        |=> o_first_clock_output)
        else $error("first output did not rise after release");

    held_low_a: assert property (@(posedge i_core_clk) // see R13
        disable iff (i_sys_rst)
        div_hold |=> !o_first_clock_output && !o_third_clock_output)
        else $error("divider output moved while held");

    second_phase_a: assert property (@(posedge i_core_clk) // see R04
        disable iff (i_sys_rst)
        !st_reg.loaded && i_output_usage_strap == LVL_ZERO
        |=> st_reg.cfg1.phase == $past(idx_b) && !o_output_on[2])
        else $error("ratio-B index not used as second phase");

    digit_order_a: assert property (@(posedge i_core_clk) // see R15
        disable iff (i_sys_rst)
        !st_reg.loaded && i_delay_range_strap == LVL_ZERO &&
        i_fine_low_strap == LVL_ONE && i_fine_high_strap == LVL_ZERO
        |=> st_reg.cfg2.phase == 4'h3)
        else $error("first strap of a pair not the low digit");

    second_ratio_a: assert property (@(posedge i_core_clk) // see R05
        disable iff (i_sys_rst)
        !st_reg.loaded && i_output_usage_strap != LVL_ONE && idx_c == 4'hf
        |=> st_reg.cfg1.ratio == 6'h20)
        else $error("ratio-C index 15 not divide by 32");

    first_ratio_a: assert property (@(posedge i_core_clk) // see R07
        disable iff (i_sys_rst)
        !st_reg.loaded && i_output_usage_strap != LVL_TWO_THIRDS &&
        idx_a == 4'h2 |=> st_reg.cfg0.ratio == 6'h03)
        else $error("ratio-A index 2 not divide by 3");

    third_ratio_a: assert property (@(posedge i_core_clk) // see R03
        disable iff (i_sys_rst)
        !st_reg.loaded && idx_b == 4'hf &&
        (i_output_usage_strap == LVL_THIRD ||
         i_output_usage_strap == LVL_ONE)
        |=> st_reg.cfg2.ratio == 6'h20)
        else $error("ratio-B index 15 not divide by 32 on third");

    third_phase_a: assert property (@(posedge i_core_clk) // see R06
        disable iff (i_sys_rst)
        !st_reg.loaded && i_output_usage_strap == LVL_ONE &&
        i_delay_range_strap != LVL_ZERO
        |=> st_reg.cfg2.phase == $past(idx_c))
        else $error("ratio-C index not used as third phase");

    short_delay_a: assert property (@(posedge i_core_clk) // see R16
        disable iff (i_sys_rst)
        !st_reg.loaded && i_delay_range_strap == LVL_THIRD &&
        i_output_usage_strap != LVL_ZERO && idx_fine == 4'h8
        |=> o_third_delay_ps == 14'h0384)
        else $error("half of 1.8 ns not 900 ps");

    delay_bypass_a: assert property (@(posedge i_core_clk) // see R16
        disable iff (i_sys_rst)
        !st_reg.loaded && i_delay_range_strap == LVL_ZERO
        |=> o_third_delay_ps == 14'h0000)
        else $error("delay word not cleared in bypass");

endmodule

/* File: tb/scd_clock_receiver.sv */
`timescale 1ns/1ps
// clock receiver on one output: times the first rise after alignment,
// the high time and the period, counted in input clock cycles
module scd_clock_receiver (
    input wire logic i_core_clk, // input clock
    input wire logic i_sys_rst, // async reset, high
    input wire logic i_align_request_n, // restarts the measurement
    input wire logic i_clk_level, // watched clock output
    output logic o_seen, // at least one rise seen
    output logic [7:0] o_first_rise, // cycles to first rise
    output logic [7:0] o_high, // high time of first pulse
    output logic [7:0] o_period // first rise to second rise
);
    logic [7:0] cnt;
    logic [7:0] last;
    logic [7:0] hrun;
    logic prev;

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst || !i_align_request_n) begin
            cnt <= 8'h00;
            last <= 8'h00;
            hrun <= 8'h00;
            prev <= 1'b1; // masks an edge pending at align
            o_seen <= 1'b0;
            o_first_rise <= 8'h00;
            o_high <= 8'h00;
            o_period <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
            prev <= i_clk_level;
            hrun <= i_clk_level ? hrun + 8'h01 : 8'h00;
            if (i_clk_level && !prev) begin
                if (!o_seen) begin
                    o_first_rise <= cnt;
                end else if (o_period == 8'h00) begin
                    o_period <= cnt - last;
                end
                last <= cnt;
                o_seen <= 1'b1;
            end
            // first fall latches the high time
            if (!i_clk_level && prev && o_seen && o_high == 8'h00) begin
                o_high <= hrun;
            end
        end
    end
endmodule

/* File: tb/scd_clock_distributor_tb.sv */
`timescale 1ns/1ps
module scd_clock_distributor_tb;
    import scd_pkg::*;

    localparam int STD_R [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16,
        18, 24, 30, 32};
    localparam int ALT_R [16] = '{7, 11, 13, 14, 17, 19, 20, 21, 22, 23,
        25, 26, 27, 28, 29, 31};
    // d,u,fine lo/hi,b lo/hi,c lo/hi,a lo/hi, two bits each
    localparam logic [19:0] CORNERS [7] = '{20'h0ff40, 20'h31c08,
        20'h00000, 20'hfffff, 20'h6f00f, 20'h994f8, 20'h62000};

    logic core_clk;
    logic rst;
    logic align_n;
    logic [19:0] straps;
    logic [2:0] lvl;
    logic [2:0] byp;
    logic [2:0] on;
    logic den;
    logic [DELAY_W-1:0] dps;
    logic loaded;
    logic aligning;
    logic seen [3];
    logic [7:0] first [3];
    logic [7:0] high [3];
    logic [7:0] period [3];
    int miscompares;
    int n_tests;
    logic [2:0] e_on;
    logic [2:0] e_byp;
    logic e_den;
    int e_ps;
    int e_r [3];
    int e_p [3];

    scd_clock_distributor u_dut (
        .i_core_clk(core_clk),
        .i_sys_rst(rst),
        .i_align_request_n(align_n),
        .i_delay_range_strap(straps[19:18]),
        .i_output_usage_strap(straps[17:16]),
        .i_fine_low_strap(straps[15:14]),
        .i_fine_high_strap(straps[13:12]),
        .i_ratio_b_low_strap(straps[11:10]),
        .i_ratio_b_high_strap(straps[9:8]),
        .i_ratio_c_low_strap(straps[7:6]),
        .i_ratio_c_high_strap(straps[5:4]),
        .i_ratio_a_low_strap(straps[3:2]),
        .i_ratio_a_high_strap(straps[1:0]),
        .o_first_clock_output(lvl[0]),
        .o_second_clock_output(lvl[1]),
        .o_third_clock_output(lvl[2]),
        .o_clock_bypass(byp),
        .o_output_on(on),
        .o_delay_enable(den),
        .o_third_delay_ps(dps),
        .o_config_loaded(loaded),
        .o_aligning(aligning)
    );

    for (genvar g = 0; g < 3; g++) begin : g_rx
        scd_clock_receiver u_rx (
            .i_core_clk(core_clk),
            .i_sys_rst(rst),
            .i_align_request_n(align_n),
            .i_clk_level(lvl[g]),
            .o_seen(seen[g]),
            .o_first_rise(first[g]),
            .o_high(high[g]),
            .o_period(period[g])
        );
    end

    always #2.5 core_clk = ~core_clk;

    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
            miscompares++;
        end
    endtask

    // expected configuration from one strap vector
    task automatic compute(input logic [19:0] v);
        int d;
        int u;
        int f;
        int b;
        int c;
        int a;
        d = v[19:18];
        u = v[17:16];
        f = v[13:12] * 4 + v[15:14];
        b = v[9:8] * 4 + v[11:10];
        c = v[5:4] * 4 + v[7:6];
        a = v[1:0] * 4 + v[3:2];
        e_on = (u == 0) ? 3'h3 : (u == 1) ? 3'h7 : (u == 2) ? 3'h6 : 3'h5;
        e_r[0] = STD_R[a];
        e_r[1] = STD_R[c];
        e_r[2] = (u == 2) ? ALT_R[a] : STD_R[b];
        e_p[0] = 0;
        e_p[1] = (u == 0) ? b : 0;
        e_p[2] = (d == 0) ? f : ((u == 3) ? c : 0);
        for (int i = 0; i < 3; i++) begin
            e_byp[i] = e_on[i] && e_r[i] == 1;
        end
        e_den = (d != 0) && e_on[2];
        e_ps = (d == 1) ? 1800 : (d == 2) ? 6000 : 11600;
        e_ps = e_den ? e_ps * f / 16 : 0;
    endtask

    task automatic check_cfg();
        chk("output_on", e_on, on);
        chk("bypass", e_byp, byp);
        chk("loaded", 1'b1, loaded);
        chk("delay_enable", e_den, den);
        chk("delay_ps", e_ps, dps);
    endtask

    task automatic run_case(input logic [19:0] v, input bit twice);
        int k;
        logic [31:0] rv;
        compute(v);
        @(posedge core_clk);
        straps <= v;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        k = 0;
        @(negedge core_clk);
        while (loaded !== 1'b1 && k < 10) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 10) begin
            miscompares++;
            summarize();
        end
        check_cfg();
        rv = $urandom;
        @(posedge core_clk);
        straps <= rv[19:0];
        // second pass aligns while the dividers are running
        repeat (twice ? 2 : 1) begin
            @(posedge core_clk);
            align_n <= 1'b0;
            @(posedge core_clk);
            align_n <= 1'b1;
            @(negedge core_clk);
            chk("aligning", 1'b1, aligning);
            @(negedge core_clk);
            chk("frozen", 3'h0, lvl);
            repeat (2) @(negedge core_clk);
            chk("aligning_e2", 1'b1, aligning);
            @(negedge core_clk);
            chk("aligning_e3", 1'b0, aligning);
            repeat (100) @(negedge core_clk);
            check_cfg();
            check_rx();
        end
    endtask

    // receiver figures after one release; off and bypassed stay quiet
    task automatic check_rx();
        string sfx;
        int ef;
        for (int i = 0; i < 3; i++) begin
            sfx = $sformatf("%0d", i);
            ef = 4 + e_p[i];
            if (e_on[i] && e_r[i] > 1) begin
                chk({"seen", sfx}, 1, seen[i]);
                chk({"first", sfx}, ef, first[i]);
                chk({"high", sfx}, e_r[i] / 2, high[i]);
                chk({"period", sfx}, e_r[i], period[i]);
            end else begin
                chk({"quiet", sfx}, 0, seen[i]);
            end
        end
    endtask

    initial begin
        logic [31:0] rv;
        core_clk = 1'b0;
        rst = 1'b1;
        align_n = 1'b1;
        straps = 20'h00000;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(89148));
        repeat (10) @(posedge core_clk);
        for (int k = 0; k < 7; k++) begin
            run_case(CORNERS[k], k < 2);
        end
        repeat (40) begin
            rv = $urandom;
            run_case(rv[19:0], rv[31]);
        end
        summarize();
    end
endmodule
